//--- src/vlim_pkg.sv
// Package: offsets, field layout, weights and state types for the voltage setting registers
package vlim_pkg;
    // Byte offsets of the two 16-bit settings
    localparam logic [7:0]  SRC_LO_ADDR    = 8'h06;
    localparam logic [7:0]  SRC_HI_ADDR    = 8'h07;
    localparam logic [7:0]  FLOOR_LO_ADDR  = 8'h0A;
    localparam logic [7:0]  FLOOR_HI_ADDR  = 8'h0B;
    // Reset values
    localparam logic [15:0] SRC_RESET      = 16'h0000;
    localparam logic [15:0] FLOOR_RESET    = 16'h0000;
    // Field layout: high-byte reserved bits and writable masks
    localparam logic [7:0]  HI_RSVD_MASK   = 8'hC0;
    localparam logic [7:0]  HI_FIELD_MASK  = 8'h3F;
    localparam logic [7:0]  FLOOR_LO_MASK  = 8'hC0;
    localparam logic [7:0]  SRC_LO_MASK    = 8'hFC;
    localparam int          FLOOR_CODE_LSB = 6;
    localparam int          SRC_CODE_LSB   = 2;
    // Floor: 64 mV steps on a 3.2 V base, default 1.28 V under unloaded bus
    localparam logic [15:0] FLOOR_STEP_MV  = 16'h0040;
    localparam logic [15:0] FLOOR_BASE_MV  = 16'h0C80;
    localparam logic [15:0] FLOOR_DROOP_MV = 16'h0500;
    // Source output: code step in microvolts, optional 1.28 V base, legal window
    localparam logic [31:0] SRC_STEP_UV    = 32'h0000_1FC5;
    localparam logic [31:0] UV_PER_MV      = 32'h0000_03E8;
    localparam logic [15:0] SRC_OFFSET_MV  = 16'h0500;
    localparam logic [15:0] SRC_MIN_MV     = 16'h0BB8;
    localparam logic [15:0] SRC_MAX_MV     = 16'h5140;

    // Register byte write or read request from the serial engine
    typedef struct packed {
        logic       wr_en;
        logic       rd_en;
        logic [7:0] addr;
        logic [7:0] wdata;
    } byte_req_t;

    // Whole state of the register bank
    typedef struct packed {
        logic [7:0]  floor_lo_stage;
        logic [7:0]  src_lo_stage;
        logic [15:0] floor_reg;
        logic [15:0] src_reg;
        logic        floor_prog;
        logic [15:0] floor_mv;
        logic [15:0] src_mv;
        logic        throttle;
        logic [7:0]  rdata;
        logic        rejected;
    } bank_state_t;

    // Floor voltage in mV from the 8-bit code
    function automatic logic [15:0] floor_code_to_mv(input logic [7:0] code);
        logic [15:0] prod;
        prod = 16'(code) * FLOOR_STEP_MV;
        return 16'(prod + FLOOR_BASE_MV);
    endfunction : floor_code_to_mv
endpackage : vlim_pkg

//--- src/src_volt_conv.sv
// Source-mode output voltage converter: code plus optional base to millivolts
`timescale 1ns/100ps
module src_volt_conv
    import vlim_pkg::*;
(
    // Code and offset select
    input  wire logic [11:0] code,
    input  wire logic        no_offset,
    // Result
    output logic [15:0]      volt_mv,
    output logic             in_range
);
    logic [31:0] scaled_mv;

    // Code scaled by the step, plus base unless the offset is switched off
    always_comb begin
        scaled_mv = (32'(code) * SRC_STEP_UV) / UV_PER_MV;
        volt_mv   = 16'(scaled_mv) + (no_offset ? 16'h0000 : SRC_OFFSET_MV);
        in_range  = (volt_mv >= SRC_MIN_MV) && (volt_mv <= SRC_MAX_MV);
    end
endmodule : src_volt_conv

//--- src/voltage_limit_setting_regs.sv
// Input floor and source-mode output voltage setting registers with byte access
`timescale 1ns/100ps
// Overview of operation
// - Floor code bits split across both bytes
// - Floor adds fixed 3.2 V base
// - Default floor is unloaded bus minus 1.28 V
// - Input below floor triggers power throttling
// - Low reserved bits are ignored
// - Twelve-bit source code split across both bytes
// - Source code LSB weighs about 8.1 mV
// - Reject source writes outside 3..20.8 V
// - Offset select removes 1.28 V source base
module voltage_limit_setting_regs
    import vlim_pkg::*;
(
    // Clock, reset, enable
    input  wire logic                 clk_sys,
    input  wire logic                 rst_n,
    input  wire logic                 clk_en,
    // Byte register port from the serial engine
    input  wire vlim_pkg::byte_req_t  req,
    output logic [7:0]                rdata,
    output logic                      write_rejected,
    // Analog side measurements and controls
    input  wire logic [15:0]          vbus_noload_mv,
    input  wire logic [15:0]          vin_mv,
    input  wire logic                 src_no_offset,
    output logic [15:0]               floor_mv,
    output logic [15:0]               src_volt_mv,
    output logic                      input_power_throttling
);
    bank_state_t st_reg;
    bank_state_t st_next;
    logic [15:0] cand_src;
    logic [15:0] cand_mv;
    logic        cand_ok;
    logic [15:0] held_mv;

    // Candidate value for a source write: staged low byte plus incoming high byte
    assign cand_src = {req.wdata & HI_FIELD_MASK, st_reg.src_lo_stage & SRC_LO_MASK};

    // Range check on the candidate before it lands
    src_volt_conv u_cand_conv (
        .code      (cand_src[SRC_CODE_LSB +: 12]),
        .no_offset (src_no_offset),
        .volt_mv   (cand_mv),
        .in_range  (cand_ok)
    );

    // Stored code converted again so a later offset change is followed on the next enabled clock
    src_volt_conv u_held_conv (
        .code      (st_reg.src_reg[SRC_CODE_LSB +: 12]),
        .no_offset (src_no_offset),
        .volt_mv   (held_mv),
        .in_range  ()
    );

    // Next-state logic for the whole bank
    always_comb begin
        st_next          = st_reg;
        st_next.rejected = 1'b0;
        // Low bytes only stage; the pair commits on the high byte
        if (req.wr_en && req.addr == FLOOR_LO_ADDR) begin
            st_next.floor_lo_stage = req.wdata & FLOOR_LO_MASK;
        end
        if (req.wr_en && req.addr == SRC_LO_ADDR) begin
            st_next.src_lo_stage = req.wdata & SRC_LO_MASK;
        end
        if (req.wr_en && req.addr == FLOOR_HI_ADDR) begin
            if ((req.wdata & HI_RSVD_MASK) != 8'h00) begin
                st_next.rejected = 1'b1;
            end else begin
                st_next.floor_reg  = {req.wdata & HI_FIELD_MASK, st_reg.floor_lo_stage};
                st_next.floor_prog = 1'b1;
            end
        end
        if (req.wr_en && req.addr == SRC_HI_ADDR) begin
            if ((req.wdata & HI_RSVD_MASK) != 8'h00 || !cand_ok) begin
                st_next.rejected = 1'b1;
            end else begin
                st_next.src_reg = cand_src;
            end
        end
        // Until the host writes, the floor tracks the unloaded bus
        if (st_reg.floor_prog) begin
            st_next.floor_mv = floor_code_to_mv(st_reg.floor_reg[FLOOR_CODE_LSB +: 8]);
        end else begin
            st_next.floor_mv = vbus_noload_mv - FLOOR_DROOP_MV;
        end
        st_next.src_mv   = held_mv;
        st_next.throttle = vin_mv < st_reg.floor_mv;
        // Readback of the stored bytes; unmapped reads give zero
        if (req.rd_en) begin
            unique case (req.addr)
                FLOOR_LO_ADDR: st_next.rdata = st_reg.floor_reg[7:0];
                FLOOR_HI_ADDR: st_next.rdata = st_reg.floor_reg[15:8];
                SRC_LO_ADDR:   st_next.rdata = st_reg.src_reg[7:0];
                SRC_HI_ADDR:   st_next.rdata = st_reg.src_reg[15:8];
                default:       st_next.rdata = 8'h00;
            endcase
        end
    end

    // State register; the enable freezes everything
    always_ff @(posedge clk_sys) begin
        if (!rst_n) begin
            st_reg.floor_lo_stage <= 8'h00;
            st_reg.src_lo_stage   <= 8'h00;
            st_reg.floor_reg      <= FLOOR_RESET;
            st_reg.src_reg        <= SRC_RESET;
            st_reg.floor_prog     <= 1'b0;
            st_reg.floor_mv       <= 16'h0000;
            st_reg.src_mv         <= 16'h0000;
            st_reg.throttle       <= 1'b0;
            st_reg.rdata          <= 8'h00;
            st_reg.rejected       <= 1'b0;
        end else if (clk_en) begin
            st_reg <= st_next;
        end
    end

    // Outputs straight from flip-flops
    assign rdata                  = st_reg.rdata;
    assign write_rejected         = st_reg.rejected;
    assign floor_mv               = st_reg.floor_mv;
    assign src_volt_mv            = st_reg.src_mv;
    assign input_power_throttling = st_reg.throttle;
endmodule : voltage_limit_setting_regs

//--- verif/vlim_properties.sv
// Port timing checker for the voltage setting registers
`timescale 1ns/100ps
module vlim_properties
    import vlim_pkg::*;
(
    // Watched ports
    input wire logic                clk_sys,
    input wire logic                rst_n,
    input wire logic                clk_en,
    input wire vlim_pkg::byte_req_t req,
    input wire logic [7:0]          rdata,
    input wire logic                write_rejected,
    input wire logic [15:0]         vbus_noload_mv,
    input wire logic [15:0]         vin_mv,
    input wire logic                src_no_offset,
    input wire logic [15:0]         floor_mv,
    input wire logic [15:0]         src_volt_mv,
    input wire logic                input_power_throttling
);
    default clocking @(posedge clk_sys); endclocking
    default disable iff (!rst_n);
    // Enabled high-byte write strobe, accepted or refused, the only place a refusal may start
    wire hi_wr = clk_en && req.wr_en && (req.addr inside {FLOOR_HI_ADDR, SRC_HI_ADDR});
    a_throttle_on: assert property (clk_en && vin_mv < floor_mv |=> input_power_throttling)
        else $error("throttling not raised");
    a_throttle_off: assert property (clk_en && vin_mv >= floor_mv |=> !input_power_throttling)
        else $error("throttling not dropped");
    a_rsvd_refused: assert property (hi_wr && req.wdata[7:6] != 2'b00 |=> write_rejected)
        else $error("reserved bits accepted");
    a_reject_cause: assert property (write_rejected |-> $past(hi_wr))
        else $error("refusal without high-byte write");
    a_floor_taken: assert property (hi_wr && req.addr == FLOOR_HI_ADDR
        && req.wdata[7:6] == 2'b00 |=> !write_rejected) else $error("floor write refused");
    a_rdata_hold: assert property ($past(rst_n) && !$past(req.rd_en) |-> $stable(rdata))
        else $error("read data moved without a read");
    // Offset select alone moves the output by exactly the base; underflow wraps harmlessly
    a_offset_step: assert property (clk_en && $rose(src_no_offset) && $stable(src_volt_mv)
        && $past(rst_n) && !$past(req.wr_en) |=> src_volt_mv == $past(src_volt_mv) - SRC_OFFSET_MV)
        else $error("offset select step wrong");
    a_reject_keeps: assert property (write_rejected && $stable(src_no_offset) |=> $stable(src_volt_mv))
        else $error("refused write changed output");
    c_reject: cover property (write_rejected);
    c_throttle: cover property ($rose(input_power_throttling));
    c_offset: cover property ($rose(src_no_offset));
endmodule : vlim_properties

//--- verif/vlim_host.sv
// Host model: byte-pair writes and byte reads on the register port
`timescale 1ns/100ps
module vlim_host
    import vlim_pkg::*;
(
    // Clock, answers and requests
    input  wire logic           clk_sys,
    input  wire logic [7:0]     rdata,
    input  wire logic           write_rejected,
    output vlim_pkg::byte_req_t req
);
    initial req = '0;
    // Low byte staged first, high byte commits; idle data inverted so it never looks valid
    task automatic wr(input logic [7:0] a, input logic [15:0] d, output logic rej);
        @(posedge clk_sys) req <= '{1'b1, 1'b0, a, d[7:0]};
        @(posedge clk_sys) req <= '{1'b1, 1'b0, a + 8'h01, d[15:8]};
        @(posedge clk_sys) req <= '{1'b0, 1'b0, a, ~d[15:8]};
        #1 rej = write_rejected;
    endtask : wr
    // Read data is taken one cycle after the strobe
    task automatic rd(input logic [7:0] a, output logic [7:0] d);
        @(posedge clk_sys) req <= '{1'b0, 1'b1, a, 8'hA5};
        @(posedge clk_sys) req <= '{1'b0, 1'b0, a, 8'h5A};
        #1 d = rdata;
    endtask : rd
endmodule : vlim_host

//--- verif/voltage_limit_setting_regs_tb.sv
// Self-checking bench for the voltage setting registers against an integer model
`timescale 1ns/100ps
module voltage_limit_setting_regs_tb;
    import vlim_pkg::*;
    logic        clk_sys = 1'b0, rst_n = 1'b0, clk_en = 1'b1, src_no_offset = 1'b0;
    logic        write_rejected, input_power_throttling, rej, exp_rej, off;
    logic [7:0]  rdata;
    logic [15:0] vbus_noload_mv = 16'h2EE0, vin_mv = 16'h0000, floor_mv, src_volt_mv, d;
    byte_req_t   req;
    int          num_errors = 0, n_compared = 0, cyc = 0, flr = -1, src = 0;
    voltage_limit_setting_regs uut (.*);
    vlim_host host (.*);
    initial forever #2.5 clk_sys = ~clk_sys;
    // Hang guard; a full run needs under 3000 cycles
    always @(posedge clk_sys) begin
        cyc <= cyc + 1;
        if (cyc == 8000) begin
            num_errors++;
            conclude();
        end
    end
    // Expected source output from the stored code
    function automatic int mv_of(int r, logic o);
        return r[13:2] * SRC_STEP_UV / UV_PER_MV + (o ? 0 : SRC_OFFSET_MV);
    endfunction : mv_of
    task automatic chk(input string n, input logic [15:0] seen, input logic [15:0] exp);
        n_compared++;
        if (seen !== exp) begin
            num_errors++;
            $display("[ERR] %s expected %h seen %h", n, exp, seen);
        end
    endtask : chk
    // Sets input voltage near the floor, lets outputs settle, then compares floor, source and throttling outputs and reads back both registers
    task automatic check_all();
        int f;
        logic [7:0] lo, hi;
        f = flr < 0 ? vbus_noload_mv - FLOOR_DROOP_MV : FLOOR_BASE_MV + flr[13:6] * FLOOR_STEP_MV;
        @(posedge clk_sys) vin_mv <= 16'(f + $urandom_range(255) - 128);
        repeat (3) @(posedge clk_sys);
        #1 chk("floor_mv", floor_mv, 16'(f));
        chk("src_volt_mv", src_volt_mv, 16'(mv_of(src, src_no_offset)));
        chk("throttling", 16'(input_power_throttling), 16'(vin_mv < f));
        host.rd(FLOOR_LO_ADDR, lo);
        host.rd(FLOOR_HI_ADDR, hi);
        chk("floor_reg", {hi, lo}, flr < 0 ? FLOOR_RESET : 16'(flr));
        host.rd(SRC_LO_ADDR, lo);
        host.rd(SRC_HI_ADDR, hi);
        chk("src_reg", {hi, lo}, 16'(src));
    endtask : check_all
    task automatic conclude();
        $display("compared %0d, errors %0d", n_compared, num_errors);
        if (num_errors == 0 && n_compared > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask : conclude
    // Random pairs alternating between registers; every sixth, always a source pair, leaves the reserved high bits random
    initial begin
        void'($urandom(32'h9121B082));
        repeat (10) @(posedge clk_sys);
        rst_n <= 1'b1;
        check_all();
        for (int i = 0; i < 48; i++) begin
            d = 16'($urandom);
            if (i % 6 != 5)
                d[15:14] = 2'b00;
            off = 1'($urandom_range(1));
            @(posedge clk_sys) src_no_offset <= off;
            exp_rej = d[15:14] != 2'b00;
            if (i[0]) begin
                exp_rej |= mv_of(d, off) < SRC_MIN_MV || mv_of(d, off) > SRC_MAX_MV;
                host.wr(SRC_LO_ADDR, d, rej);
                if (!exp_rej)
                    src = d & {HI_FIELD_MASK, SRC_LO_MASK};
            end else begin
                host.wr(FLOOR_LO_ADDR, d, rej);
                if (!exp_rej)
                    flr = d & {HI_FIELD_MASK, FLOOR_LO_MASK};
            end
            chk("write_rejected", 16'(rej), 16'(exp_rej));
            check_all();
        end
        // Frozen bank: neither a refused nor a legal pair may land while disabled
        @(posedge clk_sys) clk_en <= 1'b0;
        host.wr(FLOOR_LO_ADDR, 16'hC000, rej);
        chk("frozen_reject", 16'(rej), 16'h0000);
        host.wr(SRC_LO_ADDR, 16'h0800, rej);
        @(posedge clk_sys) clk_en <= 1'b1;
        check_all();
        // Mid-run reset brings back the tracking floor and the zero source code
        @(posedge clk_sys) rst_n <= 1'b0;
        repeat (3) @(posedge clk_sys);
        rst_n <= 1'b1;
        flr = -1;
        src = 0;
        check_all();
        conclude();
    end
endmodule : voltage_limit_setting_regs_tb
bind voltage_limit_setting_regs vlim_properties chk (.*);
